//--- hw/arf_archive_ring_file_reader.sv
// archive header bookkeeping and file-read command interpreter
`timescale 1ns/100ps
module arf_archive_ring_file_reader import arf_pkg::*; #(parameter int FIFO_DEPTH = 16) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // own bus address
   input wire logic [7:0] slave_addr,
   // request bytes from serial layer
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   // entry stored event
   input wire logic wr_valid,
   input wire logic [2:0] wr_arch,
   // storage read port
   output logic mem_rd_req,
   output logic [ARF_ADDR_W-1:0] mem_rd_addr,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   // reply bytes
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready
);
   arf_state_e st_r, st_nxt;
   logic [7:0] rxb_r [ARF_REQ_LEN];
   logic [7:0] rxb_nxt [ARF_REQ_LEN];
   logic [3:0] rxn_r, rxn_nxt;
   logic ovf_r, ovf_nxt, exc_r, exc_nxt, hsel_r, hsel_nxt, crch_r, crch_nxt;
   logic [15:0] rcrc_r, rcrc_nxt, tcrc_r, tcrc_nxt;
   logic [7:0] ecode_r, ecode_nxt, left_r, left_nxt, dat_r, dat_nxt;
   logic [2:0] pre_r, pre_nxt, arch_r, arch_nxt;
   logic [ARF_ADDR_W-1:0] addr_r, addr_nxt;
   logic [15:0] hpos_r [ARF_NARCH][ARF_NCOPY];
   logic [15:0] hold_r [ARF_NARCH][ARF_NCOPY];
   logic [15:0] hnew_r [ARF_NARCH][ARF_NCOPY];
   logic [15:0] hpos_nxt [ARF_NARCH][ARF_NCOPY];
   logic [15:0] hold_nxt [ARF_NARCH][ARF_NCOPY];
   logic [15:0] hnew_nxt [ARF_NARCH][ARF_NCOPY];
   logic [1:0] cur_r [ARF_NARCH];
   logic [1:0] cur_nxt [ARF_NARCH];
   logic [15:0] cur_pos [ARF_NARCH];
   logic [15:0] cur_old [ARF_NARCH];
   logic [15:0] cur_new [ARF_NARCH];
   logic [15:0] f_file, f_start, f_nreg, f_fidx;
   logic [7:0] n2, push_data;
   logic push_valid, push_ready, push, frame_ok;

   assign f_file = {rxb_r[4], rxb_r[5]};
   assign f_start = {rxb_r[6], rxb_r[7]};
   assign f_nreg = {rxb_r[8], rxb_r[9]};
   assign f_fidx = f_file - 16'd1;
   assign n2 = {f_nreg[6:0], 1'b0};
   assign frame_ok = rxn_r == 4'(ARF_REQ_LEN) && !ovf_r && rxb_r[0] == slave_addr
                     && rcrc_r == {rxb_r[11], rxb_r[10]};

   genvar g;
   for (g = 0; g < ARF_NARCH; g++) begin : g_cur
      assign cur_pos[g] = hpos_r[g][cur_r[g]];
      assign cur_old[g] = hold_r[g][cur_r[g]];
      assign cur_new[g] = hnew_r[g][cur_r[g]];
   end

   // copy layout: position, oldest, newest high first, then CRC low first
   function automatic logic [7:0] hdr_byte(input logic [2:0] a, input logic [ARF_ADDR_W-1:0] off);
      logic [15:0] p, o, w, c;
      logic [7:0] b;
      p = hpos_r[a][off[4:3]];
      o = hold_r[a][off[4:3]];
      w = hnew_r[a][off[4:3]];
      c = arf_crc_byte(arf_crc_byte(arf_crc_byte(ARF_CRC_INIT, p[15:8]), p[7:0]), o[15:8]);
      c = arf_crc_byte(arf_crc_byte(arf_crc_byte(c, o[7:0]), w[15:8]), w[7:0]);
      case (off[2:0])
         3'h0: b = p[15:8];
         3'h1: b = p[7:0];
         3'h2: b = o[15:8];
         3'h3: b = o[7:0];
         3'h4: b = w[15:8];
         3'h5: b = w[7:0];
         3'h6: b = c[7:0];
         default: b = c[15:8];
      endcase
      // beyond the four copies reads as zero
      return (off >= ARF_HDR_AREA) ? 8'h00 : b;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // header rings
   always_comb begin : c_hdr
      logic [1:0] s;
      logic [15:0] o, w, cap;
      s = '0;
      o = '0;
      w = '0;
      cap = '0;
      hpos_nxt = hpos_r;
      hold_nxt = hold_r;
      hnew_nxt = hnew_r;
      cur_nxt = cur_r;
      for (int a = 0; a < ARF_NARCH; a++) begin
         if (wr_valid && wr_arch == 3'(a)) begin
            s = cur_r[a] + 2'h1;
            o = cur_old[a];
            w = cur_new[a];
            cap = ARF_CAP[a];
            cur_nxt[a] = s;
            if (o == ARF_EMPTY_IDX && w == ARF_EMPTY_IDX) begin
               hpos_nxt[a][s] = 16'd1;
               hold_nxt[a][s] = 16'd0;
               hnew_nxt[a][s] = 16'd0;
            end else begin
               hpos_nxt[a][s] = (cur_pos[a] == ARF_MAXPOS) ? 16'd0 : cur_pos[a] + 16'd1;
               hnew_nxt[a][s] = (w == cap - 16'd1) ? 16'd0 : w + 16'd1;
               // full once newest has reached the end or oldest has moved
               if (o != 16'd0 || w == cap - 16'd1) begin
                  hold_nxt[a][s] = (o == cap - 16'd1) ? 16'd0 : o + 16'd1;
               end else begin
                  hold_nxt[a][s] = 16'd0;
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int a = 0; a < ARF_NARCH; a++) begin
            cur_r[a] <= ARF_CUR_RST;
            for (int k = 0; k < ARF_NCOPY; k++) begin
               hpos_r[a][k] <= 16'd0;
               hold_r[a][k] <= ARF_EMPTY_IDX;
               hnew_r[a][k] <= ARF_EMPTY_IDX;
            end
         end
      end else begin
         cur_r <= cur_nxt;
         hpos_r <= hpos_nxt;
         hold_r <= hold_nxt;
         hnew_r <= hnew_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request parse and reply sequence
   always_comb begin
      st_nxt = st_r;
      rxb_nxt = rxb_r;
      rxn_nxt = rxn_r;
      ovf_nxt = ovf_r;
      rcrc_nxt = rcrc_r;
      tcrc_nxt = tcrc_r;
      exc_nxt = exc_r;
      ecode_nxt = ecode_r;
      hsel_nxt = hsel_r;
      arch_nxt = arch_r;
      addr_nxt = addr_r;
      left_nxt = left_r;
      pre_nxt = pre_r;
      dat_nxt = dat_r;
      crch_nxt = crch_r;
      rx_ready = st_r == ARF_ST_RX;
      mem_rd_req = st_r == ARF_ST_MRD && !hsel_r;
      push_valid = st_r == ARF_ST_PRE || st_r == ARF_ST_DAT || st_r == ARF_ST_CRC;
      push = push_valid && push_ready;
      case (pre_r)
         3'h0: push_data = rxb_r[0];
         3'h1: push_data = exc_r ? ARF_FUNC_EXC : ARF_FUNC_READ;
         3'h2: push_data = exc_r ? ecode_r : n2 + 8'd2;
         3'h3: push_data = n2 + 8'd1;
         default: push_data = ARF_RESP_REF;
      endcase
      if (st_r == ARF_ST_DAT) begin
         push_data = dat_r;
      end else if (st_r == ARF_ST_CRC) begin
         push_data = crch_r ? tcrc_r[15:8] : tcrc_r[7:0];
      end
      if (push) begin
         tcrc_nxt = arf_crc_byte(tcrc_r, push_data);
      end
      case (st_r)
         ARF_ST_RX: begin
            if (rx_valid) begin
               if (rxn_r < 4'(ARF_REQ_LEN)) begin
                  rxb_nxt[rxn_r] = rx_data;
                  rxn_nxt = rxn_r + 4'h1;
               end else begin
                  ovf_nxt = 1'b1;
               end
               if (rxn_r < 4'(ARF_CRC_POS)) begin
                  rcrc_nxt = arf_crc_byte(rcrc_r, rx_data);
               end
               if (rx_last) begin
                  st_nxt = ARF_ST_CHK;
               end
            end
         end
         ARF_ST_CHK: begin
            rxn_nxt = '0;
            ovf_nxt = 1'b0;
            rcrc_nxt = ARF_CRC_INIT;
            tcrc_nxt = ARF_CRC_INIT;
            pre_nxt = '0;
            crch_nxt = 1'b0;
            exc_nxt = 1'b1;
            hsel_nxt = !f_fidx[0];
            arch_nxt = f_fidx[3:1];
            left_nxt = n2;
            st_nxt = frame_ok ? ARF_ST_PRE : ARF_ST_RX;
            // reference type byte deliberately ignored
            if (rxb_r[1] != ARF_FUNC_READ) begin
               ecode_nxt = ARF_EXC_FUNC;
            end else if (rxb_r[2] != ARF_SUB_BYTES) begin
               ecode_nxt = ARF_EXC_VALUE;
            end else if (f_file == 16'd0 || f_file > ARF_FILE_MAX) begin
               ecode_nxt = ARF_EXC_ADDR;
            end else if (f_nreg == 16'd0 || f_nreg > ARF_MAX_REGS) begin
               ecode_nxt = ARF_EXC_VALUE;
            end else begin
               exc_nxt = 1'b0;
               if (!f_fidx[0]) begin
                  addr_nxt = ARF_ADDR_W'({f_start, 3'h0});
               end else begin
                  addr_nxt = ARF_ADDR_W'(ARF_BASE[f_fidx[3:1]] + f_start * ARF_ESIZE[f_fidx[3:1]]);
               end
            end
         end
         ARF_ST_PRE: begin
            if (push) begin
               pre_nxt = pre_r + 3'h1;
               if (pre_r + 3'h1 == (exc_r ? ARF_PRE_EXC : ARF_PRE_NORM)) begin
                  st_nxt = exc_r ? ARF_ST_CRC : ARF_ST_MRD;
               end
            end
         end
         ARF_ST_MRD: begin
            if (hsel_r) begin
               dat_nxt = hdr_byte(arch_r, addr_r);
               st_nxt = ARF_ST_DAT;
            end else if (mem_rd_valid) begin
               dat_nxt = mem_rd_data;
               st_nxt = ARF_ST_DAT;
            end
         end
         ARF_ST_DAT: begin
            if (push) begin
               addr_nxt = addr_r + 1'b1;
               left_nxt = left_r - 8'd1;
               st_nxt = (left_r == 8'd1) ? ARF_ST_CRC : ARF_ST_MRD;
            end
         end
         ARF_ST_CRC: begin
            if (push) begin
               crch_nxt = 1'b1;
               tcrc_nxt = tcrc_r;
               st_nxt = crch_r ? ARF_ST_RX : ARF_ST_CRC;
            end
         end
         default: st_nxt = ARF_ST_RX;
      endcase
   end

   assign mem_rd_addr = addr_r;

   always_ff @(posedge clk) begin
      rxb_r <= rxb_nxt;
      if (rst) begin
         st_r <= ARF_ST_RX;
         rxn_r <= '0;
         ovf_r <= 1'b0;
         rcrc_r <= ARF_CRC_INIT;
         tcrc_r <= ARF_CRC_INIT;
         exc_r <= 1'b0;
         ecode_r <= '0;
         hsel_r <= 1'b0;
         arch_r <= '0;
         addr_r <= '0;
         left_r <= '0;
         pre_r <= '0;
         dat_r <= '0;
         crch_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         rxn_r <= rxn_nxt;
         ovf_r <= ovf_nxt;
         rcrc_r <= rcrc_nxt;
         tcrc_r <= tcrc_nxt;
         exc_r <= exc_nxt;
         ecode_r <= ecode_nxt;
         hsel_r <= hsel_nxt;
         arch_r <= arch_nxt;
         addr_r <= addr_nxt;
         left_r <= left_nxt;
         pre_r <= pre_nxt;
         dat_r <= dat_nxt;
         crch_r <= crch_nxt;
      end
   end

   // reply buffer lets the serial side stall without losing bytes
   arf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_data(push_data),
      .in_ready(push_ready),
      .out_valid(tx_valid),
      .out_data(tx_data),
      .out_ready(tx_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_ok;
   logic [15:0] wr_pos, wr_old, wr_new, wr_cap;
   assign wr_ok = wr_valid && wr_arch < 3'(ARF_NARCH);
   assign wr_pos = wr_ok ? cur_pos[wr_arch] : 16'd0;
   assign wr_old = wr_ok ? cur_old[wr_arch] : 16'd0;
   assign wr_new = wr_ok ? cur_new[wr_arch] : 16'd0;
   assign wr_cap = wr_ok ? ARF_CAP[wr_arch] : 16'd0;

   AST_FIRST_ENTRY: assert property (wr_ok && wr_old == ARF_EMPTY_IDX |=>
      cur_pos[$past(wr_arch)] == 16'd1 && cur_old[$past(wr_arch)] == 16'd0 && cur_new[$past(wr_arch)] == 16'd0)
      else $error("first entry header wrong");
   AST_POS_STEP: assert property (wr_ok && wr_old != ARF_EMPTY_IDX |=>
      cur_pos[$past(wr_arch)] == (($past(wr_pos) == ARF_MAXPOS) ? 16'd0 : $past(wr_pos) + 16'd1))
      else $error("position number step wrong");
   AST_FILL: assert property (wr_ok && wr_old == 16'd0 && wr_new < wr_cap - 16'd2 |=>
      cur_old[$past(wr_arch)] == 16'd0 && cur_new[$past(wr_arch)] == $past(wr_new) + 16'd1)
      else $error("fill step wrong");
   AST_WRAP: assert property (wr_ok && wr_old == 16'd0 && wr_new == wr_cap - 16'd1 |=>
      cur_new[$past(wr_arch)] == 16'd0 && cur_old[$past(wr_arch)] == 16'd1)
      else $error("wrap step wrong");
   AST_RING: assert property (wr_ok |=> cur_r[$past(wr_arch)] == $past(cur_r[wr_arch]) + 2'h1)
      else $error("ring slot not advanced");
   AST_BAD_FILE: assert property (st_r == ARF_ST_CHK && frame_ok && rxb_r[1] == ARF_FUNC_READ
      && rxb_r[2] == ARF_SUB_BYTES && (f_file == 16'd0 || f_file > ARF_FILE_MAX)
      |=> st_r == ARF_ST_PRE && exc_r && ecode_r == ARF_EXC_ADDR)
      else $error("bad file not refused");
   // busy states must leave the byte counter as the check state cleared it
   AST_RX_HOLD: assert property (!rx_ready && st_r != ARF_ST_CHK |-> rxn_r == 4'h0 && !ovf_r)
      else $error("request taken while busy");
   AST_LEN_BYTE: assert property (st_r == ARF_ST_PRE && push && pre_r == 3'h2 && !exc_r
      |-> push_data == 8'(f_nreg * 16'd2 + 16'd2) && left_r == 8'(f_nreg * 16'd2))
      else $error("reply length wrong");
   AST_START: assert property ($rose(st_r == ARF_ST_MRD) && $past(st_r) == ARF_ST_PRE && !hsel_r
      |-> mem_rd_addr == ARF_ADDR_W'(ARF_BASE[arch_r] + f_start * ARF_ESIZE[arch_r]))
      else $error("start address wrong");
   AST_CRC_PAIR: assert property (st_r == ARF_ST_CRC && !crch_r && push
      |=> st_r == ARF_ST_CRC && crch_r ##[0:64] st_r == ARF_ST_RX)
      else $error("crc bytes not paired");
   COV_ARCHIVE: cover property (st_r == ARF_ST_MRD && mem_rd_valid && mem_rd_req);
   COV_HEADER: cover property (st_r == ARF_ST_MRD && hsel_r);
   COV_EXC: cover property (st_r == ARF_ST_PRE && exc_r && push);
   COV_WRAP: cover property (wr_ok && wr_old != 16'd0 && wr_old != ARF_EMPTY_IDX);
endmodule // arf_archive_ring_file_reader

//--- hw/arf_pkg.sv
// constants, types and checksum helper for the archive ring file reader
package arf_pkg;
   localparam int ARF_NARCH = 6;
   localparam int ARF_NCOPY = 4;
   localparam int ARF_ADDR_W = 19;
   localparam int ARF_REQ_LEN = 12;
   localparam int ARF_CRC_POS = 10;
   localparam logic [15:0] ARF_MAXPOS = 16'd9999;
   localparam logic [15:0] ARF_EMPTY_IDX = 16'hFFFF;
   localparam logic [15:0] ARF_FILE_MAX = 16'd12;
   localparam logic [15:0] ARF_MAX_REGS = 16'd125;
   localparam logic [15:0] ARF_CRC_INIT = 16'hFFFF;
   localparam logic [15:0] ARF_CRC_POLY = 16'hA001;
   localparam logic [7:0] ARF_FUNC_READ = 8'h14;
   localparam logic [7:0] ARF_FUNC_EXC = 8'h94;
   localparam logic [7:0] ARF_SUB_BYTES = 8'h07;
   localparam logic [7:0] ARF_RESP_REF = 8'h06;
   localparam logic [7:0] ARF_EXC_FUNC = 8'h01;
   localparam logic [7:0] ARF_EXC_ADDR = 8'h02;
   localparam logic [7:0] ARF_EXC_VALUE = 8'h03;
   localparam logic [2:0] ARF_PRE_NORM = 3'h5;
   localparam logic [2:0] ARF_PRE_EXC = 3'h3;
   localparam logic [18:0] ARF_HDR_AREA = 19'h00020;
   localparam logic [1:0] ARF_CUR_RST = 2'h3;
   // custody parameter, parameter, event, minutes, daily, monthly
   localparam logic [15:0] ARF_CAP [ARF_NARCH] = '{16'd300, 16'd300, 16'd200, 16'd9000, 16'd100, 16'd25};
   localparam logic [15:0] ARF_ESIZE [ARF_NARCH] = '{16'd34, 16'd34, 16'd12, 16'd40, 16'd40, 16'd40};
   localparam logic [18:0] ARF_BASE [ARF_NARCH] = '{19'd0, 19'd10200, 19'd20400, 19'd22800, 19'd382800, 19'd386800};

   typedef enum logic [5:0] {
      ARF_ST_RX = 6'h01,
      ARF_ST_CHK = 6'h02,
      ARF_ST_PRE = 6'h04,
      ARF_ST_MRD = 6'h08,
      ARF_ST_DAT = 6'h10,
      ARF_ST_CRC = 6'h20
   } arf_state_e;

   function automatic logic [15:0] arf_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ ARF_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

//--- hw/arf_fifo.sv
// reply byte fifo with valid and ready on both sides
`timescale 1ns/100ps
module arf_fifo #(parameter int W = 8, parameter int D = 16) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = cnt_r != CW'(D);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = (wp_r == PW'(D - 1)) ? '0 : PW'(wp_r + 1'b1);
      end
      if (pop) begin
         rp_nxt = (rp_r == PW'(D - 1)) ? '0 : PW'(rp_r + 1'b1);
      end
      if (push && !pop) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
   end

   // storage keeps no reset: only the count and pointers decide what is valid
   always_ff @(posedge clk) begin
      mem_r <= mem_nxt;
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // arf_fifo

//--- bench/arf_master.sv
// modbus master model: sends file-read requests and collects replies
`timescale 1ns/100ps
module arf_master (
   // clock
   input wire logic clk,
   // request side
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   input wire logic rx_ready,
   // reply side
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] rep[$];
   logic stall_r = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
   end
   // slow consumer, every other cycle, so the reply fifo backs up
   always @(posedge clk) begin
      if (tx_valid && tx_ready)
         rep.push_back(tx_data);
      stall_r <= #1 ~stall_r;
   end
   assign tx_ready = stall_r;
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   // one frame, one sub-request, one byte a cycle; caller waits for rx_ready
   task automatic send(input logic [7:0] f[$]);
      logic [15:0] c;
      c = crc(f);
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      rep.delete();
      foreach (f[i]) begin
         rx_valid = 1'b1;
         rx_data = f[i];
         rx_last = (i == f.size() - 1);
         @(posedge clk);
         #1;
      end
      rx_valid = 1'b0;
      rx_last = 1'b0;
   endtask
   // current copy: its ring successor does not hold the next position number
   function automatic int cur_copy();
      int p, q;
      for (int c = 0; c < 4; c++) begin
         p = {rep[5 + c * 8], rep[6 + c * 8]};
         q = {rep[5 + (c + 1) % 4 * 8], rep[6 + (c + 1) % 4 * 8]};
         if (q != ((p == 9999) ? 0 : p + 1))
            return c;
      end
      return 0;
   endfunction
   // entries held, taken from the current copy of a four-copy header reply
   function automatic int entries(input int cap);
      int c;
      c = 5 + cur_copy() * 8;
      return count({rep[c + 2], rep[c + 3]}, {rep[c + 4], rep[c + 5]}, cap);
   endfunction
   // entry count from the current header copy
   function automatic int count(input logic [15:0] o, input logic [15:0] n, input int cap);
      if (o == 16'hFFFF && n == 16'hFFFF)
         return 0;
      if (o <= n)
         return n - o + 1;
      return cap - o + n + 1;
   endfunction
endmodule // arf_master

//--- bench/test_arf_archive_ring_file_reader.sv
// testbench for the archive ring file reader
`timescale 1ns/100ps
module test_arf_archive_ring_file_reader import arf_pkg::*;;
   typedef logic [7:0] arf_q_t[$];
   localparam logic [7:0] ADDR = 8'h2A;
   logic clk, rst, rx_valid, rx_last, rx_ready, wr_valid, mem_rd_req, mem_rd_valid, tx_valid, tx_ready;
   logic [7:0] rx_data, mem_rd_data, tx_data, slave_addr;
   logic [2:0] wr_arch;
   logic [ARF_ADDR_W-1:0] mem_rd_addr;
   int mismatches = 0;
   int n_tests = 0;
   assign slave_addr = ADDR;
   // storage answers at once with a byte that depends on the address
   assign mem_rd_valid = mem_rd_req;
   assign mem_rd_data = e(mem_rd_addr);
   arf_archive_ring_file_reader #(.FIFO_DEPTH(16)) arf_archive_ring_file_reader_inst (.clk(clk), .rst(rst),
      .slave_addr(slave_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
      .wr_valid(wr_valid), .wr_arch(wr_arch), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
      .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready));
   arf_master arf_master_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] e(input logic [18:0] a);
      return a[7:0] ^ a[18:11];
   endfunction
   function automatic arf_q_t frm(input logic [7:0] fn, input logic [15:0] file, st, rg);
      return '{ADDR, fn, 8'h07, 8'h00, file[15:8], file[7:0], st[15:8], st[7:0], rg[15:8], rg[7:0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic results();
      $display("mismatches %0d checks %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic req(input arf_q_t f, input int n);
      int k;
      k = 0;
      arf_master_inst.send(f);
      while ((arf_master_inst.rep.size() < n || !rx_ready) && k < 3000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 3000) begin
         check(16'h0001, 16'h0000, "reply timeout");
         results();
      end
      repeat (6) @(posedge clk);
      #1;
      check(arf_master_inst.rep.size(), n, "reply length");
      if (n > 0) begin
         check(arf_master_inst.crc(arf_master_inst.rep), 16'h0000, "reply crc");
         check(arf_master_inst.rep[0], ADDR, "reply address");
      end
   endtask
   task automatic rd(input logic [15:0] file, st, rg);
      req(frm(8'h14, file, st, rg), 2 * rg + 7);
      check(arf_master_inst.rep[1], 8'h14, "function");
      check(arf_master_inst.rep[2], 2 * rg + 2, "byte count");
      check(arf_master_inst.rep[3], 2 * rg + 1, "sub length");
      check(arf_master_inst.rep[4], 8'h06, "reference");
   endtask
   task automatic exc(input arf_q_t f, input logic [7:0] code);
      req(f, 5);
      check(arf_master_inst.rep[1], 8'h94, "exception function");
      check(arf_master_inst.rep[2], code, "exception code");
   endtask
   // header copy c of the reply against position, oldest, newest
   task automatic hdr(input int c, input logic [15:0] p, o, n);
      logic [7:0] b[$];
      logic [15:0] k;
      b = '{p[15:8], p[7:0], o[15:8], o[7:0], n[15:8], n[7:0]};
      k = arf_master_inst.crc(b);
      b.push_back(k[7:0]);
      b.push_back(k[15:8]);
      foreach (b[i])
         check(arf_master_inst.rep[5 + c * 8 + i], b[i], "header byte");
   endtask
   task automatic wr(input logic [2:0] a, input int n);
      wr_valid = 1'b1;
      wr_arch = a;
      repeat (n) @(posedge clk);
      #1;
      wr_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_empty();
      rd(16'd5, 16'd0, 16'd16);
      for (int c = 0; c < 4; c++)
         hdr(c, 16'h0000, 16'hFFFF, 16'hFFFF);
      check(16'(arf_master_inst.entries(200)), 16'd0, "empty entries");
   endtask
   task automatic t_fill();
      wr(3'd2, 1);
      rd(16'd5, 16'd0, 16'd16);
      check(16'(arf_master_inst.entries(200)), 16'd1, "one entry");
      wr(3'd2, 2);
      rd(16'd5, 16'd0, 16'd16);
      check(16'(arf_master_inst.entries(200)), 16'd3, "filling entries");
      hdr(0, 16'd1, 16'd0, 16'd0);
      hdr(1, 16'd2, 16'd0, 16'd1);
      hdr(2, 16'd3, 16'd0, 16'd2);
      hdr(3, 16'h0000, 16'hFFFF, 16'hFFFF);
   endtask
   task automatic t_wrap();
      wr(3'd5, 26);
      rd(16'd11, 16'd0, 16'd16);
      hdr(0, 16'd25, 16'd0, 16'd24);
      hdr(1, 16'd26, 16'd1, 16'd0);
      hdr(2, 16'd23, 16'd0, 16'd22);
      check(16'(arf_master_inst.entries(25)), 16'd25, "full entries");
   endtask
   task automatic t_posmax();
      wr(3'd0, 10000);
      rd(16'd1, 16'd2, 16'd8);
      hdr(0, 16'd9999, 16'd99, 16'd98);
      hdr(1, 16'd0, 16'd100, 16'd99);
   endtask
   task automatic t_data();
      arf_q_t f;
      f = frm(8'h14, 16'd6, 16'd7, 16'd13);
      f[3] = 8'h5A;
      req(f, 33);
      for (int i = 0; i < 26; i++)
         check(arf_master_inst.rep[5 + i], e(19'd20484 + i), "event data");
      rd(16'd4, 16'd0, 16'd125);
      for (int f2 = 2; f2 <= 12; f2 += 2) begin
         rd(f2, 16'd0, 16'd1);
         check(arf_master_inst.rep[6], e(ARF_BASE[f2 / 2 - 1] + 19'd1), "file map");
      end
   endtask
   task automatic t_refuse();
      arf_q_t f;
      exc(frm(8'h03, 16'd6, 16'd0, 16'd1), 8'h01);
      exc(frm(8'h14, 16'd13, 16'd0, 16'd1), 8'h02);
      exc(frm(8'h14, 16'd0, 16'd0, 16'd1), 8'h02);
      exc(frm(8'h14, 16'd6, 16'd0, 16'd126), 8'h03);
      f = frm(8'h14, 16'd6, 16'd0, 16'd1);
      f[2] = 8'h08;
      exc(f, 8'h03);
      f[0] = ADDR + 8'h01;
      req(f, 0);
      f = frm(8'h14, 16'd6, 16'd0, 16'd1);
      req(f[0:8], 0);
      f.push_back(8'h00);
      req(f, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      wr_valid = 1'b0;
      wr_arch = 3'd0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      t_empty();
      t_fill();
      t_wrap();
      t_data();
      t_refuse();
      t_posmax();
      results();
   end
endmodule // test_arf_archive_ring_file_reader
